// ### shared/spisb_pkg.sv
// constants shared by the serial status and data buffer block
package spisb_pkg;

	// register indices as printed, byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h10;
	localparam logic [7:0] IDX_STAT = 8'h11;
	localparam logic [7:0] IDX_DATA = 8'h12;
	localparam logic [7:0] ADDR_CTRL = 8'h40;
	localparam logic [7:0] ADDR_STAT = 8'h44;
	localparam logic [7:0] ADDR_DATA = 8'h48;

	// control register fields
	localparam int CTRL_RIE = 7;
	localparam int CTRL_HOST = 5;
	localparam int CTRL_EN = 1;
	localparam int CTRL_TIE = 0;

	// status and control register fields
	localparam int STAT_RF = 7;
	localparam int STAT_ERROR_IRQ_ENABLE = 6;
	localparam int STAT_OVR = 5;
	localparam int STAT_MODE_FAULT_FLAG = 4;
	localparam int STAT_TE = 3;
	localparam int STAT_FDE = 2;
	localparam int STAT_RATE_HI = 1;
	localparam int STAT_RATE_LO = 0;

	// reset values
	localparam logic RST_HOST = 1'h1;
	localparam logic RST_TE = 1'h1;
	localparam logic [1:0] RST_RATE = 2'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// master rate divisors for rate codes 0 to 2; code 3 uses DIV_128, DIV_CODE3 is unused
	localparam logic [6:0] DIV_CODE0 = 7'h02;
	localparam logic [6:0] DIV_CODE1 = 7'h08;
	localparam logic [6:0] DIV_CODE2 = 7'h20;
	localparam logic [6:0] DIV_CODE3 = 7'h7F;
	localparam logic [7:0] DIV_128 = 8'h80;

	localparam logic [2:0] LAST_BIT = 3'h7;

	// pin synchroniser lanes
	localparam int PIN_SCLK = 0;
	localparam int PIN_SS = 1;
	localparam int PIN_MOSI = 2;
	localparam int PIN_MISO = 3;
	localparam int PIN_N = 4;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {
		SPISB_IDLE,
		SPISB_XFER
	} spisb_state_t;

endpackage

// ### verilog/spisb_core.sv
// serial status flags, data buffers, rate divider and register slave
`timescale 1ns/100ps
// Notes on behaviour
// - byte into receive buffer sets receive_full_flag, irq
// - any data buffer read clears receive_full_flag
// - reset clears flags, enables, rate; sets transmit_empty
// - error irq only with error_irq_enable set
// - byte completed while receive full sets overrun
// - overrun keeps old byte, drops new one
// - status read then data read clears overrun
// - slave select rising mid-transfer faults a slave
// - slave select low faults a master
// - status read then data write clears mode fault
// - transmit buffer handoff sets transmit_empty, irq
// - enabled idle handoff within two bus cycles, unless a master has a mode fault or a slave still holds a loaded byte
// - busy slave defers handoff until transfer ends
// - mode fault set only with fault_detect_enable
// - fault detect enable keeps select as input while enabled
// - master without fault detect frees select pin
// - enabled slave never frees select pin
// - rate code picks divisor 2, 8, 32, 128
// - serial clock is base clock over twice divisor
// - data writes transmit buffer, reads receive buffer
// - deselected slave floats output, ignores clocks
module spisb_core
	import spisb_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial link pins
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic slave_select_n,
	// system side
	output logic select_pin_gpio_free,
	output logic cpu_irq
);

	// bus state
	logic aw_hold, w_hold, wbit_en;
	logic [7:0] aw_addr, w_byte;
	logic next_aw_hold, next_w_hold, next_wbit_en;
	logic [7:0] next_aw_addr, next_w_byte;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic wr_go, rd_go;

	// register state
	logic rie, host, en, tie, error_irq_enable, fde;
	logic [1:0] rate;
	logic rf, ovr, mode_fault_flag, te, arm_ovr, arm_mode_fault_flag;
	logic [7:0] txb, rxb;
	logic next_rie, next_host, next_en, next_tie, next_error_irq_enable, next_fde;
	logic [1:0] next_rate;
	logic next_rf, next_ovr, next_mode_fault_flag, next_te, next_arm_ovr, next_arm_mode_fault_flag;
	logic [7:0] next_txb, next_rxb;

	// engine state
	spisb_state_t state, next_state;
	logic [7:0] sh, next_sh;
	logic rx_bit, next_rx_bit, sh_loaded, next_sh_loaded;
	logic [2:0] bitcnt, next_bitcnt;
	logic [6:0] div_cnt, next_div_cnt;
	logic [7:0] half_div;
	logic sclk_q, next_sclk_q;
	logic next_sclk_oe, next_mosi_oe, next_miso_oe, next_irq, next_gpio_free;

	// pin synchronisers: lane meta feeds only the sync stage
	logic [PIN_N-1:0] pin_meta, pin_sync, pin_prev;
	logic ss_n_s, sclk_rise, sclk_fall, ss_rise, data_rd, data_wr, stat_rd;
	logic [7:0] done_byte;
	logic [7:0] stat_val, ctrl_val;

	assign ss_n_s = pin_sync[PIN_SS];
	assign sclk_rise = pin_sync[PIN_SCLK] & ~pin_prev[PIN_SCLK];
	assign sclk_fall = ~pin_sync[PIN_SCLK] & pin_prev[PIN_SCLK];
	assign ss_rise = ss_n_s & ~pin_prev[PIN_SS];
	assign done_byte = {sh[6:0], rx_bit};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_meta <= '1;
			pin_sync <= '1;
			pin_prev <= '1;
		end else begin
			pin_meta <= {miso_in, mosi_in, slave_select_n, serial_clock_pin_in};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// divisor lookup; half period equals the divisor in base clocks
	always_comb begin
		case (rate)
			// eight bits so that the largest divisor fits exactly
			2'h0: half_div = {1'b0, DIV_CODE0};
			2'h1: half_div = {1'b0, DIV_CODE1};
			2'h2: half_div = {1'b0, DIV_CODE2};
			default: half_div = DIV_128;
		endcase
	end

	assign stat_val = {rf, error_irq_enable, ovr, mode_fault_flag, te, fde, rate};
	assign ctrl_val = {rie, 1'b0, host, 3'b000, en, tie};

	// bus slave: address and data taken in either order
	always_comb begin
		next_aw_hold = aw_hold;
		next_w_hold = w_hold;
		next_aw_addr = aw_addr;
		next_w_byte = w_byte;
		next_wbit_en = wbit_en;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		wr_go = 1'b0;
		rd_go = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_byte = s_axi_wdata[7:0];
			next_wbit_en = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_hold && w_hold && !s_axi_bvalid) begin
			wr_go = 1'b1;
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			if (aw_addr == ADDR_CTRL || aw_addr == ADDR_STAT || aw_addr == ADDR_DATA) begin
				next_bresp = RESP_OKAY;
			end else begin
				next_bresp = RESP_SLVERR;
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rd_go = 1'b1;
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			next_rdata = '0;
			case (s_axi_araddr)
				ADDR_CTRL: next_rdata = {24'h000000, ctrl_val};
				ADDR_STAT: next_rdata = {24'h000000, stat_val};
				ADDR_DATA: next_rdata = {24'h000000, rxb};
				default: next_rresp = RESP_SLVERR;
			endcase
		end
		next_awready = !next_aw_hold && !next_bvalid;
		next_wready = !next_w_hold && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_byte <= 8'h00;
			wbit_en <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			aw_addr <= next_aw_addr;
			w_byte <= next_w_byte;
			wbit_en <= next_wbit_en;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
		end
	end

	// access side effects; a masked byte lane still counts as an access
	assign data_rd = rd_go && s_axi_araddr == ADDR_DATA;
	assign stat_rd = rd_go && s_axi_araddr == ADDR_STAT;
	assign data_wr = wr_go && aw_addr == ADDR_DATA;

	// flags, buffers and shift engine
	always_comb begin
		next_rie = rie;
		next_host = host;
		next_en = en;
		next_tie = tie;
		next_error_irq_enable = error_irq_enable;
		next_fde = fde;
		next_rate = rate;
		next_rf = rf;
		next_ovr = ovr;
		next_mode_fault_flag = mode_fault_flag;
		next_te = te;
		next_arm_ovr = arm_ovr;
		next_arm_mode_fault_flag = arm_mode_fault_flag;
		next_txb = txb;
		next_rxb = rxb;
		next_state = state;
		next_sh = sh;
		next_rx_bit = rx_bit;
		next_sh_loaded = sh_loaded;
		next_bitcnt = bitcnt;
		next_div_cnt = div_cnt;
		next_sclk_q = sclk_q;

		// clears first so that hardware sets below win
		if (stat_rd && ovr) begin
			next_arm_ovr = 1'b1;
		end
		if (stat_rd && mode_fault_flag) begin
			next_arm_mode_fault_flag = 1'b1;
		end
		if (data_rd) begin
			next_rf = 1'b0;
			if (arm_ovr) begin
				next_ovr = 1'b0;
				next_arm_ovr = 1'b0;
			end
		end
		if (wr_go && wbit_en) begin
			case (aw_addr)
				ADDR_CTRL: begin
					next_rie = w_byte[CTRL_RIE];
					next_host = w_byte[CTRL_HOST];
					next_en = w_byte[CTRL_EN];
					next_tie = w_byte[CTRL_TIE];
				end
				ADDR_STAT: begin
					next_error_irq_enable = w_byte[STAT_ERROR_IRQ_ENABLE];
					next_fde = w_byte[STAT_FDE];
					next_rate = {w_byte[STAT_RATE_HI], w_byte[STAT_RATE_LO]};
				end
				ADDR_DATA: begin
					next_txb = w_byte;
					next_te = 1'b0;
				end
				default: begin
				end
			endcase
		end
		if (data_wr && arm_mode_fault_flag) begin
			next_mode_fault_flag = 1'b0;
			next_arm_mode_fault_flag = 1'b0;
		end

		// mode fault detection, never cleared by dropping the enable
		if (en && fde && !host && state == SPISB_XFER && ss_rise) begin
			next_mode_fault_flag = 1'b1;
		end
		if (en && fde && host && !ss_n_s) begin
			next_mode_fault_flag = 1'b1;
		end

		if (!en) begin
			next_state = SPISB_IDLE;
			next_sclk_q = 1'b0;
			next_sh_loaded = 1'b0;
			next_div_cnt = 7'h00;
		end else if (host) begin
			case (state)
				SPISB_IDLE: begin
					if (!te && !mode_fault_flag) begin
						next_sh = txb;
						next_te = 1'b1;
						next_state = SPISB_XFER;
						next_bitcnt = 3'h0;
						next_div_cnt = 7'h00;
					end
				end
				SPISB_XFER: begin
					if ({1'b0, div_cnt} == half_div - 8'h01) begin
						next_div_cnt = 7'h00;
						next_sclk_q = !sclk_q;
						if (!sclk_q) begin
							next_rx_bit = pin_sync[PIN_MISO];
						end else begin
							next_sh = done_byte;
							next_bitcnt = bitcnt + 3'h1;
							if (bitcnt == LAST_BIT) begin
								next_state = SPISB_IDLE;
							end
						end
					end else begin
						next_div_cnt = div_cnt + 7'h01;
					end
				end
				default: next_state = SPISB_IDLE;
			endcase
		end else begin
			next_sclk_q = 1'b0;
			// a deselected slave ignores clocks even mid-byte
			if (!ss_n_s) begin
				if (sclk_rise) begin
					next_rx_bit = pin_sync[PIN_MOSI];
					if (state == SPISB_IDLE) begin
						next_state = SPISB_XFER;
						next_bitcnt = 3'h0;
					end
				end
				if (sclk_fall && state == SPISB_XFER) begin
					next_sh = done_byte;
					next_bitcnt = bitcnt + 3'h1;
					if (bitcnt == LAST_BIT) begin
						next_state = SPISB_IDLE;
						next_sh_loaded = 1'b0;
					end
				end
			end
			// hand off only while idle; a busy slave waits for the byte end
			if (state == SPISB_IDLE && next_state == SPISB_IDLE && !sh_loaded && !te) begin
				next_sh = txb;
				next_te = 1'b1;
				next_sh_loaded = 1'b1;
			end
		end

		// byte completion into the receive buffer
		if (state == SPISB_XFER && next_state == SPISB_IDLE && en) begin
			if (rf) begin
				next_ovr = 1'b1;
			end else begin
				next_rxb = done_byte;
				next_rf = 1'b1;
			end
		end

		next_sclk_oe = next_en && next_host && !next_mode_fault_flag;
		next_mosi_oe = next_sclk_oe;
		next_miso_oe = next_en && !next_host && !ss_n_s;
		next_gpio_free = !next_en || (next_host && !next_fde);
		next_irq = (next_rie && next_rf) || (next_tie && next_te)
			|| (next_error_irq_enable && (next_ovr || next_mode_fault_flag));
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rie <= 1'b0;
			host <= RST_HOST;
			en <= 1'b0;
			tie <= 1'b0;
			error_irq_enable <= 1'b0;
			fde <= 1'b0;
			rate <= RST_RATE;
			rf <= 1'b0;
			ovr <= 1'b0;
			mode_fault_flag <= 1'b0;
			te <= RST_TE;
			arm_ovr <= 1'b0;
			arm_mode_fault_flag <= 1'b0;
			txb <= RST_BYTE;
			rxb <= RST_BYTE;
			state <= SPISB_IDLE;
			sh <= RST_BYTE;
			rx_bit <= 1'b0;
			sh_loaded <= 1'b0;
			bitcnt <= 3'h0;
			div_cnt <= 7'h00;
			sclk_q <= 1'b0;
			serial_clock_pin_out <= 1'b0;
			serial_clock_pin_oe <= 1'b0;
			mosi_out <= 1'b0;
			mosi_oe <= 1'b0;
			miso_out <= 1'b0;
			miso_oe <= 1'b0;
			select_pin_gpio_free <= 1'b1;
			cpu_irq <= 1'b0;
		end else begin
			rie <= next_rie;
			host <= next_host;
			en <= next_en;
			tie <= next_tie;
			error_irq_enable <= next_error_irq_enable;
			fde <= next_fde;
			rate <= next_rate;
			rf <= next_rf;
			ovr <= next_ovr;
			mode_fault_flag <= next_mode_fault_flag;
			te <= next_te;
			arm_ovr <= next_arm_ovr;
			arm_mode_fault_flag <= next_arm_mode_fault_flag;
			txb <= next_txb;
			rxb <= next_rxb;
			state <= next_state;
			sh <= next_sh;
			rx_bit <= next_rx_bit;
			sh_loaded <= next_sh_loaded;
			bitcnt <= next_bitcnt;
			div_cnt <= next_div_cnt;
			sclk_q <= next_sclk_q;
			serial_clock_pin_out <= next_sclk_q;
			serial_clock_pin_oe <= next_sclk_oe;
			mosi_out <= next_sh[7];
			mosi_oe <= next_mosi_oe;
			miso_out <= next_sh[7];
			miso_oe <= next_miso_oe;
			select_pin_gpio_free <= next_gpio_free;
			cpu_irq <= next_irq;
		end
	end

endmodule

// ### verif/spisb_sva.sv
// port assertions for the serial status block
`timescale 1ns/100ps
module spisb_sva(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins
	input wire logic serial_clock_pin_out,
	input wire logic miso_oe,
	input wire logic slave_select_n,
	input wire logic cpu_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_rst; disable iff (1'b0) rst |=> !cpu_irq && !s_axi_bvalid && !s_axi_rvalid; endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read response dropped");
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	// both halves held one cycle, then the response register
	property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_bans: assert property (p_bans) else $error("write answer late");
	property p_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	// two sync stages plus the output register
	property p_desel; slave_select_n [*4] |=> !miso_oe; endproperty
	a_desel: assert property (p_desel) else $error("deselected slave drives data");
	property p_sclk; $rose(serial_clock_pin_out) |=> serial_clock_pin_out; endproperty
	a_sclk: assert property (p_sclk) else $error("serial clock half period short");
endmodule
bind spisb_core spisb_sva spisb_sva_i(.sys_clk(sys_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.serial_clock_pin_out(serial_clock_pin_out), .miso_oe(miso_oe),
	.slave_select_n(slave_select_n), .cpu_irq(cpu_irq));

// ### verif/spisb_remote.sv
// remote serial device model for the far end of the link
`timescale 1ns/100ps
module spisb_remote(
	// pacing clock
	input wire logic sys_clk,
	// lines driven by the block
	input wire logic sclk_dev,
	input wire logic mosi_dev,
	// lines driven by this model
	output logic sclk_rm,
	output logic mosi_rm,
	output logic miso_rm,
	output logic ss_n,
	// byte seen on the block's data out
	output logic [7:0] got
);
	logic [7:0] tx = 8'h00;
	logic [7:0] sh = 8'h00;
	int cnt = 0;
	initial begin
		sclk_rm = 1'b0;
		mosi_rm = 1'b1;
		ss_n = 1'b1;
		got = 8'h00;
	end
	assign miso_rm = sh[7];
	// as slave: capture on rising edge, next bit out on falling edge
	always @(posedge sclk_dev) begin
		got <= {got[6:0], mosi_dev};
		cnt <= cnt + 1;
	end
	always @(negedge sclk_dev) begin
		sh <= (cnt % 8 == 0) ? tx : {sh[6:0], ~sh[0]};
	end
	task load(input logic [7:0] b);
		tx = b;
		sh = b;
	endtask
	// as master: four-cycle half periods, above the block's three-cycle floor
	task send(input logic [7:0] b, input int nb);
		int i;
		ss_n <= 1'b0;
		for (i = 0; i < nb; i++) begin
			mosi_rm <= b[7 - i];
			repeat (4) @(posedge sys_clk);
			sclk_rm <= 1'b1;
			repeat (4) @(posedge sys_clk);
			sclk_rm <= 1'b0;
		end
		repeat (4) @(posedge sys_clk);
		ss_n <= 1'b1;
		mosi_rm <= ~b[8 - nb];
	endtask
endmodule

// ### verif/testbench.sv
// self-checking bench for the serial status block
`timescale 1ns/100ps
module testbench;
	import spisb_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata;
	logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, gpio, irq;
	logic r_sclk, r_mosi, r_miso, r_ss;
	logic [7:0] r_got, v;
	int fail_count = 0;
	int tests_run = 0;
	always #2.5 sys_clk = ~sys_clk;
	spisb_core spisb_core_i(.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.serial_clock_pin_in(r_sclk), .serial_clock_pin_out(sclk_o), .serial_clock_pin_oe(sclk_oe),
		.mosi_in(r_mosi), .mosi_out(mosi_o), .mosi_oe(mosi_oe), .miso_in(r_miso),
		.miso_out(miso_o), .miso_oe(miso_oe), .slave_select_n(r_ss),
		.select_pin_gpio_free(gpio), .cpu_irq(irq));
	spisb_remote spisb_remote_i(.sys_clk(sys_clk), .sclk_dev(sclk_o), .mosi_dev(mosi_o),
		.sclk_rm(r_sclk), .mosi_rm(r_mosi), .miso_rm(r_miso), .ss_n(r_ss), .got(r_got));
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task tmo;
		fail_count++;
		$display("BAD %0t wait limit", $time);
		results;
	endtask
	// ready and valid are sampled mid-cycle, where they are settled for the next edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge sys_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			@(posedge sys_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		if (n == 100) tmo;
	endtask
	task rd(input logic [7:0] a);
		int n;
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge sys_clk);
			ta = arvalid && arready;
			tr = rvalid;
			v = rdata[7:0];
			r = rresp;
			@(posedge sys_clk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		if (n == 100) tmo;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a);
		chk(v & m, e);
	endtask
	task wait_rf;
		int n;
		for (n = 0; n < 3000; n++) begin
			rd(ADDR_STAT);
			if (v[STAT_RF] === 1'b1) break;
		end
		if (n == 3000) tmo;
	endtask
	task wait_sclk(input logic l);
		int n;
		for (n = 0; n < 1000; n++) begin
			@(negedge sys_clk);
			if (sclk_o === l) break;
		end
		if (n == 1000) tmo;
	endtask
	// counts remote clock edges so no status read arms a flag clear
	task wait_byte;
		int n;
		int b;
		b = spisb_remote_i.cnt + 8;
		for (n = 0; n < 500 && spisb_remote_i.cnt < b; n++) @(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		if (n == 500) tmo;
	endtask
	task t_reset;
		rchk(ADDR_CTRL, 8'hFF, 8'h20);
		rchk(ADDR_STAT, 8'hFF, 8'h08);
		rd(8'h4C);
		chk(r, RESP_SLVERR);
	endtask
	task t_rate;
		int c;
		int k;
		int dv[4] = '{2, 8, 32, 128};
		wr(ADDR_CTRL, 8'h22);
		chk(sclk_oe, 1'b1);
		chk(gpio, 1'b1);
		for (c = 0; c < 4; c++) begin
			wr(ADDR_STAT, 8'(c));
			wr(ADDR_DATA, 8'hC3 ^ 8'(c));
			rchk(ADDR_STAT, 8'h08, 8'h08);
			wait_sclk(1'b0);
			wait_sclk(1'b1);
			for (k = 0; k < 300 && sclk_o === 1'b1; k++) @(negedge sys_clk);
			chk(32'(k), 32'(dv[c]));
			@(posedge sys_clk);
			wait_rf;
			chk(r_got, 8'hC3 ^ 8'(c));
			rd(ADDR_DATA);
		end
	endtask
	task t_rx;
		wr(ADDR_STAT, 8'h01);
		wr(ADDR_CTRL, 8'hA2);
		spisb_remote_i.load(8'h3C);
		wr(ADDR_DATA, 8'h5A);
		wait_rf;
		chk(irq, 1'b1);
		chk(r_got, 8'h5A);
		rchk(ADDR_DATA, 8'hFF, 8'h3C);
		chk(v == 8'h5A, 1'b0);
		rchk(ADDR_STAT, 8'h80, 8'h00);
		chk(irq, 1'b0);
		wr(ADDR_CTRL, 8'h22);
	endtask
	task t_ovr;
		spisb_remote_i.load(8'h11);
		wr(ADDR_DATA, 8'h01);
		wait_byte;
		spisb_remote_i.load(8'h22);
		wr(ADDR_DATA, 8'h02);
		wait_byte;
		wr(ADDR_STAT, 8'h41);
		repeat (2) @(posedge sys_clk);
		chk(irq, 1'b1);
		wr(ADDR_STAT, 8'h01);
		repeat (2) @(posedge sys_clk);
		chk(irq, 1'b0);
		rchk(ADDR_DATA, 8'hFF, 8'h11);
		rchk(ADDR_STAT, 8'h20, 8'h20);
		rd(ADDR_DATA);
		rchk(ADDR_STAT, 8'h20, 8'h00);
	endtask
	task t_mode_fault_flag;
		wr(ADDR_STAT, 8'h05);
		repeat (3) @(posedge sys_clk);
		chk(gpio, 1'b0);
		spisb_remote_i.ss_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rchk(ADDR_STAT, 8'h10, 8'h10);
		chk(sclk_oe, 1'b0);
		chk(mosi_oe, 1'b0);
		spisb_remote_i.ss_n <= 1'b1;
		wr(ADDR_STAT, 8'h01);
		rchk(ADDR_STAT, 8'h10, 8'h10);
		chk(gpio, 1'b1);
		wr(ADDR_DATA, 8'hE7);
		wait_rf;
		rd(ADDR_DATA);
		rchk(ADDR_STAT, 8'h10, 8'h00);
		spisb_remote_i.ss_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rchk(ADDR_STAT, 8'h10, 8'h00);
		spisb_remote_i.ss_n <= 1'b1;
		wr(ADDR_CTRL, 8'h23);
		chk(irq, 1'b1);
	endtask
	task t_slave;
		wr(ADDR_CTRL, 8'h02);
		wr(ADDR_STAT, 8'h04);
		repeat (3) @(posedge sys_clk);
		chk(gpio, 1'b0);
		wr(ADDR_DATA, 8'h96);
		spisb_remote_i.ss_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk(miso_oe, 1'b1);
		chk(miso_o, 1'b1);
		spisb_remote_i.ss_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(miso_oe, 1'b0);
		spisb_remote_i.send(8'h69, 8);
		wait_rf;
		rchk(ADDR_DATA, 8'hFF, 8'h69);
		spisb_remote_i.send(8'hFF, 4);
		repeat (4) @(posedge sys_clk);
		rchk(ADDR_STAT, 8'h10, 8'h10);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset;
		t_rate;
		t_rx;
		t_ovr;
		t_mode_fault_flag;
		t_slave;
		results;
	end
endmodule
